// File: design/asbm_pkg.sv
// Shared constants for the system bus master port and its slave end.
// Notes on behaviour
// - Master issues only address and sequential cycles.
// - Bus cycles start at falling clock edge; here they start at the rising edge.
// - Address half cycle, transaction code full ahead.
// - Access commits only when code says sequential.
// - Data moves at end of sequential cycle.
// - Burst addresses step by four or two.
// - Transaction code refers to next bus cycle.
// - Direction fixed throughout a burst.
// - Slave qualifies every address with transaction code.
// - After buffered write, one address cycle gap.
// - Slave copes with tightest spacing, may wait.
// - Slave strobes not decoded combinationally from address.
// - Read then write next word is non-sequential.
// - Size fixed in burst; no byte bursts.
// - Address outputs hold between accesses.
// - Codes: 00 address, 10 non-sequential, 01 reserved.
// - Request bus with areq; honour grant, select.
// - Code 11 marks a sequential data cycle.
// - Master never issues the non-sequential code.
// - Slave raises wait; master stalls bus cycle.
// - Error sampled on sequential cycles, not buffered writes.
package asbm_pkg;
   localparam logic [1:0] TRAN_ADDR = 2'h0;
   localparam logic [1:0] TRAN_RSVD = 2'h1;
   localparam logic [1:0] TRAN_NSEQ = 2'h2;
   localparam logic [1:0] TRAN_SEQ  = 2'h3;
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [31:0] STEP_WORD = 32'h4;
   localparam logic [31:0] STEP_HALF = 32'h2;
   localparam logic [7:0]  LEN_ONE   = 8'h1;
   localparam logic [7:0]  LEN_ZERO  = 8'h0;
   localparam logic [7:0]  LEN_TWO   = 8'h2;
endpackage

// File: design/asbm_if.sv
// Interface joining the bus master port to the slave end.
`timescale 1ns/1ps
interface asbm_if;
   logic [31:0] ba;
   logic        bwrite;
   logic [1:0]  bsize;
   logic [1:0]  btran;
   logic [31:0] bd_wr;
   logic [31:0] bd_rd;
   logic        bwait;
   logic        berror;
   logic        areq;
   logic        agnt;
   logic        dsel;
   modport master (output ba, bwrite, bsize, btran, bd_wr, areq,
                   input bd_rd, bwait, berror, agnt, dsel);
   modport slave  (input ba, bwrite, bsize, btran, bd_wr, areq,
                   output bd_rd, bwait, berror, agnt, dsel);
endinterface

// File: design/asbm_master.sv
// Bus master port: turns burst requests into address and sequential bus cycles.
`timescale 1ns/1ps
module asbm_master
(
   input  wire logic        i_core_clk,
   input  wire logic        i_sys_rst,
   asbm_if.master           bus,
   input  wire logic        i_req_valid,
   output logic             o_req_ready,
   input  wire logic [31:0] i_req_addr,
   input  wire logic        i_req_write,
   input  wire logic        i_req_buffered,
   input  wire logic [1:0]  i_req_size,
   input  wire logic [7:0]  i_req_len,
   input  wire logic        i_wr_valid,
   output logic             o_wr_ready,
   input  wire logic [31:0] i_wr_data,
   output logic             o_rd_valid,
   output logic [31:0]      o_rd_data,
   output logic             o_done,
   output logic             o_abort,
   output logic             o_test_master,
   output logic             o_test_slave
);
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_ADDR = 3'b010,
      ST_SEQ  = 3'b100
   } asbm_st_t;

   typedef struct packed
   {
      asbm_st_t    st;
      logic [31:0] ba;
      logic        bwrite;
      logic [1:0]  bsize;
      logic [1:0]  btran;
      logic [31:0] bd_wr;
      logic        buffered;
      logic [7:0]  left;
      logic        err;
      logic        rd_valid;
      logic [31:0] rd_data;
      logic        done;
      logic        abort;
      logic        tm;
      logic        ts;
   } asbm_mst_t;

   asbm_mst_t s_q;
   asbm_mst_t s_d;
   logic      take;
   logic      last;
   logic [7:0]  req_left;
   logic [31:0] beat_step;
   logic        seq_next;

   always_comb
   begin
      // Byte transfers never form a burst, and a zero length means one beat.
      if (i_req_size == asbm_pkg::SIZE_BYTE)
      begin
         req_left = asbm_pkg::LEN_ONE;
      end
      else if (i_req_len == asbm_pkg::LEN_ZERO)
      begin
         req_left = asbm_pkg::LEN_ONE;
      end
      else
      begin
         req_left = i_req_len;
      end
   end

   always_comb
   begin
      if (s_q.bsize == asbm_pkg::SIZE_WORD)
      begin
         beat_step = asbm_pkg::STEP_WORD;
      end
      else
      begin
         beat_step = asbm_pkg::STEP_HALF;
      end
   end

   always_comb
   begin
      // The code names the following bus cycle, so the second last beat ends the run.
      if (s_q.left == asbm_pkg::LEN_TWO)
      begin
         seq_next = 1'b0;
      end
      else
      begin
         seq_next = 1'b1;
      end
   end


   always_comb
   begin
      s_d          = s_q;
      s_d.rd_valid = 1'b0;
      s_d.done     = 1'b0;
      s_d.abort    = 1'b0;
      s_d.tm       = bus.agnt;
      s_d.ts       = bus.dsel;
      take         = 1'b0;
      last         = (s_q.left == asbm_pkg::LEN_ONE);
      case (s_q.st)
         ST_IDLE:
         begin
            s_d.btran = asbm_pkg::TRAN_ADDR;
            if (i_req_valid && bus.agnt)
            begin
               take       = 1'b1;
               s_d.ba     = i_req_addr;
               s_d.bwrite = i_req_write;
               s_d.bsize  = i_req_size;
               s_d.buffered = i_req_write && i_req_buffered;
               // Byte transfers are always single.
               s_d.left   = req_left;
               s_d.bd_wr  = i_wr_data;
               s_d.btran  = asbm_pkg::TRAN_SEQ;
               s_d.err    = 1'b0;
               s_d.st     = ST_ADDR;
            end
         end
         ST_ADDR:
         begin
            // Address cycle is done; the memory cycle follows.
            s_d.btran = last ? asbm_pkg::TRAN_ADDR : asbm_pkg::TRAN_SEQ;
            s_d.st    = ST_SEQ;
         end
         ST_SEQ:
         begin
            if (!bus.bwait)
            begin
               if (bus.berror && !s_q.buffered)
               begin
                  s_d.abort = 1'b1;
                  s_d.err   = 1'b1;
               end
               if (!s_q.bwrite)
               begin
                  s_d.rd_valid = 1'b1;
                  s_d.rd_data  = bus.bd_rd;
               end
               if (last || (bus.berror && !s_q.buffered))
               begin
                  s_d.done  = 1'b1;
                  s_d.btran = asbm_pkg::TRAN_ADDR;
                  s_d.st    = ST_IDLE;
                  // Next access after a buffered write may follow with one gap.
                  if (s_q.buffered && i_req_valid && bus.agnt)
                  begin
                     take       = 1'b1;
                     s_d.ba     = i_req_addr;
                     s_d.bwrite = i_req_write;
                     s_d.bsize  = i_req_size;
                     s_d.buffered = i_req_write && i_req_buffered;
                     s_d.left   = req_left;
                     s_d.bd_wr  = i_wr_data;
                     s_d.btran  = asbm_pkg::TRAN_SEQ;
                     s_d.err    = 1'b0;
                     s_d.st     = ST_ADDR;
                  end
               end
               else
               begin
                  s_d.left  = s_q.left - asbm_pkg::LEN_ONE;
                  s_d.ba    = s_q.ba + beat_step;
                  s_d.bd_wr = i_wr_data;
                  s_d.btran = seq_next ? asbm_pkg::TRAN_SEQ : asbm_pkg::TRAN_ADDR;
               end
            end
         end
         default:
         begin
            s_d.st    = ST_IDLE;
            s_d.btran = asbm_pkg::TRAN_ADDR;
         end
      endcase
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         s_q        <= '0;
         s_q.st     <= ST_IDLE;
         s_q.btran  <= asbm_pkg::TRAN_ADDR;
         s_q.bsize  <= asbm_pkg::SIZE_WORD;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign o_req_ready   = take;
   assign o_wr_ready    = s_q.bwrite && (s_q.st == ST_SEQ) && !bus.bwait;
   assign o_rd_valid    = s_q.rd_valid;
   assign o_rd_data     = s_q.rd_data;
   assign o_done        = s_q.done;
   assign o_abort       = s_q.abort;
   assign o_test_master = s_q.tm;
   assign o_test_slave  = s_q.ts;
   assign bus.ba        = s_q.ba;
   assign bus.bwrite    = s_q.bwrite;
   assign bus.bsize     = s_q.bsize;
   assign bus.btran     = s_q.btran;
   assign bus.bd_wr     = s_q.bd_wr;
   assign bus.areq      = i_req_valid || (s_q.st != ST_IDLE);
endmodule

// File: design/asbm_slave.sv
// Slave end: memory controller and arbiter side of the system bus.
`timescale 1ns/1ps
module asbm_slave
(
   input  wire logic        i_core_clk,
   input  wire logic        i_sys_rst,
   asbm_if.slave            bus,
   input  wire logic        i_grant_en,
   input  wire logic        i_test_sel,
   input  wire logic [3:0]  i_wait_cycles,
   input  wire logic        i_err_inject,
   input  wire logic [31:0] i_rd_data,
   output logic             o_acc_valid,
   output logic [31:0]      o_acc_addr,
   output logic             o_acc_write,
   output logic [1:0]       o_acc_size,
   output logic [31:0]      o_acc_wdata
);
   typedef struct packed
   {
      logic        mem;
      logic [3:0]  wcnt;
      logic        acc_valid;
      logic [31:0] acc_addr;
      logic        acc_write;
      logic [1:0]  acc_size;
      logic [31:0] acc_wdata;
      logic [31:0] rd;
   } asbm_slv_t;

   asbm_slv_t s_q;
   asbm_slv_t s_d;
   logic      stall;

   always_comb
   begin
      s_d           = s_q;
      s_d.acc_valid = 1'b0;
      stall         = s_q.mem && (s_q.wcnt != 4'h0);
      if (stall)
      begin
         s_d.wcnt = s_q.wcnt - 4'h1;
      end
      else
      begin
         if (s_q.mem)
         begin
            s_d.acc_valid = 1'b1;
            // The address on the bus during a memory cycle is that beat's address.
            s_d.acc_addr  = bus.ba;
            s_d.acc_write = bus.bwrite;
            s_d.acc_size  = bus.bsize;
            s_d.acc_wdata = bus.bd_wr;
         end
         // Code seen at a bus cycle boundary names the next bus cycle.
         s_d.mem   = (bus.btran == asbm_pkg::TRAN_SEQ);
         s_d.wcnt  = i_wait_cycles;
         s_d.rd    = i_rd_data;
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign bus.bwait   = stall;
   assign bus.berror  = s_q.mem && !stall && i_err_inject;
   assign bus.bd_rd   = s_q.rd;
   assign bus.agnt    = i_grant_en && bus.areq;
   assign bus.dsel    = i_test_sel;
   assign o_acc_valid = s_q.acc_valid;
   assign o_acc_addr  = s_q.acc_addr;
   assign o_acc_write = s_q.acc_write;
   assign o_acc_size  = s_q.acc_size;
   assign o_acc_wdata = s_q.acc_wdata;
endmodule

// File: sim/asbm_asserts.sv
// Checker of the bus rules seen between the master port and the slave end.
`timescale 1ns/1ps
module asbm_asserts
(
   input  wire logic        i_core_clk,
   input  wire logic        i_sys_rst,
   input  wire logic [31:0] ba,
   input  wire logic        bwrite,
   input  wire logic [1:0]  bsize,
   input  wire logic [1:0]  btran,
   input  wire logic        bwait,
   input  wire logic        agnt
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   property p_no_rsvd; btran != asbm_pkg::TRAN_RSVD; endproperty
   a_no_rsvd: assert property (p_no_rsvd) else $error("reserved code seen");
   property p_no_nseq; btran != asbm_pkg::TRAN_NSEQ; endproperty
   a_no_nseq: assert property (p_no_nseq) else $error("nonseq code seen");
   property p_rst_idle; $fell(i_sys_rst) |-> btran == asbm_pkg::TRAN_ADDR; endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset");
   property p_dir_hold;
      btran == asbm_pkg::TRAN_SEQ && $past(btran) == asbm_pkg::TRAN_SEQ && !$past(bwait)
         |-> $stable(bwrite) && $stable(bsize);
   endproperty
   a_dir_hold: assert property (p_dir_hold) else $error("burst kind changed");
   property p_no_byte_burst;
      btran == asbm_pkg::TRAN_SEQ && $past(btran) == asbm_pkg::TRAN_SEQ
         |-> bsize != asbm_pkg::SIZE_BYTE;
   endproperty
   a_no_byte_burst: assert property (p_no_byte_burst) else $error("byte burst");
   property p_addr_hold;
      btran == asbm_pkg::TRAN_ADDR && $past(btran) == asbm_pkg::TRAN_ADDR |-> $stable(ba);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("idle address moved");
   property p_wait_hold; bwait |=> $stable(ba) && $stable(bwrite); endproperty
   a_wait_hold: assert property (p_wait_hold) else $error("moved during wait");
   property p_grant;
      btran == asbm_pkg::TRAN_SEQ && $past(btran) == asbm_pkg::TRAN_ADDR |-> $past(agnt);
   endproperty
   a_grant: assert property (p_grant) else $error("access without grant");
endmodule

// File: sim/asb_bus_master_port_bench.sv
// Bench joining the master port and the slave end and driving both user sides.
`timescale 1ns/1ps
module asb_bus_master_port_bench;
   logic        clk, rst, valid, wr, bufw, grant, tsel, err;
   logic        ready, rdv, done, abrt, tm, ts, accv, accw, wrdy;
   logic [31:0] addr, acca, rdat, accd;
   logic [1:0]  size, accs;
   logic [7:0]  len;
   logic [3:0]  waits;
   int          fails, tests_run, cycles;
   localparam logic [31:0] RD = 32'hC0DE1234;
   localparam logic [31:0] WD = 32'h5A5A0F0F;
   asbm_if i_asbm_if ();
   asbm_master i_asbm_master (.i_core_clk(clk), .i_sys_rst(rst), .bus(i_asbm_if),
      .i_req_valid(valid), .o_req_ready(ready), .i_req_addr(addr), .i_req_write(wr),
      .i_req_buffered(bufw), .i_req_size(size), .i_req_len(len), .i_wr_valid(1'b1),
      .o_wr_ready(wrdy), .i_wr_data(WD), .o_rd_valid(rdv), .o_rd_data(rdat),
      .o_done(done), .o_abort(abrt), .o_test_master(tm), .o_test_slave(ts));
   asbm_slave i_asbm_slave (.i_core_clk(clk), .i_sys_rst(rst), .bus(i_asbm_if),
      .i_grant_en(grant), .i_test_sel(tsel), .i_wait_cycles(waits), .i_err_inject(err),
      .i_rd_data(RD), .o_acc_valid(accv), .o_acc_addr(acca), .o_acc_write(accw),
      .o_acc_size(accs), .o_acc_wdata(accd));
   asbm_asserts i_asbm_asserts (.i_core_clk(clk), .i_sys_rst(rst), .ba(i_asbm_if.ba),
      .bwrite(i_asbm_if.bwrite), .bsize(i_asbm_if.bsize), .btran(i_asbm_if.btran),
      .bwait(i_asbm_if.bwait), .agnt(i_asbm_if.agnt));
   task automatic end_of_test();
      $display("tests_run=%0d fails=%0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Issues one request and follows its beats on the slave side.
   task automatic run(input logic [31:0] a, input logic w, b, input logic [1:0] s,
      input logic [7:0] n, input logic [3:0] wt, input logic e, input int step, nb, ab);
      int beats;
      int aborts;
      int wrdys;
      beats = 0;
      aborts = 0;
      wrdys = 0;
      @(posedge clk);
      addr <= a;
      wr <= w;
      bufw <= b;
      size <= s;
      len <= n;
      waits <= wt;
      err <= e;
      valid <= 1'b1;
      repeat (40)
      begin
         @(negedge clk);
         if (ready === 1'b1)
            break;
      end
      @(posedge clk);
      valid <= 1'b0;
      repeat (80)
      begin
         @(negedge clk);
         if (accv === 1'b1)
         begin
            check(acca, a + beats * step);
            check(accw, w);
            check(accs, s);
            if (w)
               check(accd, WD);
            beats++;
         end
         aborts += int'(abrt === 1'b1);
         wrdys += int'(wrdy === 1'b1);
         if (rdv === 1'b1)
            check(rdat, RD);
         if (done === 1'b1)
            break;
      end
      if (nb >= 0)
      begin
         check(beats, nb);
         check(wrdys, w ? nb : 0);
      end
      check(aborts != 0, ab);
   endtask
   task automatic t_single();
      run(32'h100, 0, 0, asbm_pkg::SIZE_WORD, 1, 0, 0, 4, 1, 0);
   endtask
   task automatic t_wr_burst();
      run(32'h200, 1, 0, asbm_pkg::SIZE_WORD, 4, 2, 0, 4, 4, 0);
   endtask
   task automatic t_half();
      run(32'h302, 0, 0, asbm_pkg::SIZE_HALF, 3, 1, 0, 2, 3, 0);
   endtask
   task automatic t_byte();
      run(32'h401, 0, 0, asbm_pkg::SIZE_BYTE, 4, 0, 0, 1, 1, 0);
   endtask
   task automatic t_error();
      run(32'h500, 0, 0, asbm_pkg::SIZE_WORD, 1, 0, 1, 4, -1, 1);
      run(32'h600, 1, 1, asbm_pkg::SIZE_WORD, 1, 0, 1, 4, -1, 0);
   endtask
   task automatic t_buffered();
      run(32'h700, 1, 1, asbm_pkg::SIZE_WORD, 2, 0, 0, 4, 2, 0);
      run(32'h900, 0, 0, asbm_pkg::SIZE_WORD, 2, 0, 0, 4, 2, 0);
   endtask
   task automatic t_grant();
      @(posedge clk);
      grant <= 1'b0;
      tsel <= 1'b1;
      valid <= 1'b1;
      repeat (6) @(posedge clk);
      #1;
      check(ready, 0);
      check(i_asbm_if.areq, 1);
      check(ts, 1);
      check(tm, 0);
      @(posedge clk);
      valid <= 1'b0;
      grant <= 1'b1;
      tsel <= 1'b0;
   endtask
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fails++;
         end_of_test();
      end
   end
   initial
   begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   initial
   begin
      {rst, valid, wr, bufw, err, tsel, grant} = 7'h41;
      {addr, size, len, waits} = '0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_single();
      t_wr_burst();
      t_half();
      t_byte();
      t_error();
      t_buffered();
      t_grant();
      repeat (4) @(posedge clk);
      end_of_test();
   end
endmodule
